/* core/ppfs_pin_cell.sv */
// Purpose: Output multiplexer for one pin, picking port or alternate drive.
// Assumes: Caller tells which alternate codes exist on this pin.
// Notes:   Codes without a function fall back to plain port use.
`timescale 1ns/1ps
module ppfs_pin_cell
   import ppfs_pkg::*;
(
   input  wire logic [1:0] code,
   input  wire logic       alt1_ok,
   input  wire logic       alt2_ok,
   input  wire logic       port_val,
   input  wire logic       port_drv,
   input  wire logic       alt1_val,
   input  wire logic       alt1_drv,
   input  wire logic       alt2_val,
   input  wire logic       alt2_drv,
   output logic            mux_val,
   output logic            mux_drv,
   output logic            alt1_own
);

   always_comb
   begin
      mux_val  = port_val;
      mux_drv  = port_drv;
      alt1_own = 1'b0;
      case (code)
         PPFS_FN_ALT1:
         begin
            if (alt1_ok)
            begin
               mux_val  = alt1_val;
               mux_drv  = alt1_drv;
               alt1_own = 1'b1;
            end
         end
         PPFS_FN_ALT2:
         begin
            if (alt2_ok)
            begin
               mux_val = alt2_val;
               mux_drv = alt2_drv;
            end
         end
         default:
         begin
            mux_val = port_val;
            mux_drv = port_drv;
         end
      endcase
   end

endmodule : ppfs_pin_cell

/* core/ppfs_pkg.sv */
// Purpose: Shared constants and types for the port 0 pin function select block.
// Assumes: Registers are reached over APB with 32-bit data, one word per register.
// Notes:   Register indices are word indices; byte address is four times the index.
package ppfs_pkg;

   localparam int          PPFS_NPINS      = 8;
   localparam int          PPFS_ADDR_W     = 20;

   // Word indices of the registers.
   localparam int          PPFS_IDX_SEL_LO = 32'h0000_52A0;
   localparam int          PPFS_IDX_SEL_HI = 32'h0000_52A1;
   localparam int          PPFS_IDX_IEN    = 32'h0000_520A;
   localparam int          PPFS_IDX_DIN    = 32'h0000_5200;
   localparam int          PPFS_IDX_DOUT   = 32'h0000_5201;
   localparam int          PPFS_IDX_OEN    = 32'h0000_5202;

   localparam logic [PPFS_ADDR_W-1:0] PPFS_ADDR_SEL_LO = PPFS_ADDR_W'(PPFS_IDX_SEL_LO * 4);
   localparam logic [PPFS_ADDR_W-1:0] PPFS_ADDR_SEL_HI = PPFS_ADDR_W'(PPFS_IDX_SEL_HI * 4);
   localparam logic [PPFS_ADDR_W-1:0] PPFS_ADDR_IEN    = PPFS_ADDR_W'(PPFS_IDX_IEN * 4);
   localparam logic [PPFS_ADDR_W-1:0] PPFS_ADDR_DIN    = PPFS_ADDR_W'(PPFS_IDX_DIN * 4);
   localparam logic [PPFS_ADDR_W-1:0] PPFS_ADDR_DOUT   = PPFS_ADDR_W'(PPFS_IDX_DOUT * 4);
   localparam logic [PPFS_ADDR_W-1:0] PPFS_ADDR_OEN    = PPFS_ADDR_W'(PPFS_IDX_OEN * 4);

   // Reset values.
   localparam logic [7:0]  PPFS_RST_SEL    = 8'h00;
   localparam logic [7:0]  PPFS_RST_IEN    = 8'hFF;
   localparam logic [7:0]  PPFS_RST_DOUT   = 8'h00;
   localparam logic [7:0]  PPFS_RST_OEN    = 8'h00;

   // Field layout: pin i of a select register sits at bits 2*(i mod 4)+1 .. 2*(i mod 4).
   localparam int          PPFS_FIELD_W    = 2;
   localparam int          PPFS_REG_W      = 8;

   // Pins that have a first and a second alternate function.
   localparam logic [7:0]  PPFS_ALT1_MASK  = 8'hED;
   localparam logic [7:0]  PPFS_ALT2_MASK  = 8'h41;

   // Pins that carry timer external clock inputs.
   localparam int          PPFS_PIN_T0_CLK = 1;
   localparam int          PPFS_PIN_T1_CLK = 4;

   typedef enum logic [1:0]
   {
      PPFS_FN_PORT = 2'h0,
      PPFS_FN_ALT1 = 2'h1,
      PPFS_FN_ALT2 = 2'h2,
      PPFS_FN_RSVD = 2'h3
   } ppfs_fn_t;

endpackage : ppfs_pkg

/* core/ppfs_top.sv */
// Purpose: Pin function select for the eight pins of port 0 with an APB register file.
// Assumes: Pin and peripheral inputs are synchronous to sys_clk.
// Notes:   All outputs are registered, so pin changes lag a write by one cycle.
// Overview of operation
// - Input enable 1 passes pin level to readback
// - Input enable 0 blocks the pin input path
// - Select registers: four 2-bit fields, pin order
// - Fields reset to port function, read-writable
// - Pin 3 code 1: timer0 B out/capture
// - Pin 2 code 1: timer0 A out/capture
// - Pin 1 only port and timer0 external clock
// - Pin 0: code 2 regulator monitor, 1 RF clock
// - Pin 7 code 1 drives buzzer
// - Pin 6: code 2 inverted buzzer, 1 timer1 B
// - Pin 5 code 1: timer1 A out/capture
// - Pin 4 only port and timer1 external clock
// - Input enables reset to one
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module ppfs_top
   import ppfs_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   rstn,
   input  wire logic [PPFS_ADDR_W-1:0] paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [7:0]             pin_in,
   output logic      [7:0]             pin_out,
   output logic      [7:0]             pin_oe,
   input  wire logic                   timer0_compare_out_a,
   input  wire logic                   timer0_compare_out_b,
   input  wire logic                   timer1_compare_out_a,
   input  wire logic                   timer1_compare_out_b,
   input  wire logic                   timer0_capture_mode,
   input  wire logic                   timer1_capture_mode,
   input  wire logic                   buzzer_out,
   input  wire logic                   rf_converter_clock_out,
   input  wire logic                   regulator_monitor_out,
   output logic                        timer0_capture_in_a,
   output logic                        timer0_capture_in_b,
   output logic                        timer1_capture_in_a,
   output logic                        timer1_capture_in_b,
   output logic                        timer0_ext_clock_in,
   output logic                        timer1_ext_clock_in
);

   function automatic logic addr_hit(input logic [PPFS_ADDR_W-1:0] a,
                                     input logic [PPFS_ADDR_W-1:0] target);
      addr_hit = (a == target);
   endfunction : addr_hit

   logic [7:0]  sel_lo_q;
   logic [7:0]  sel_hi_q;
   logic [7:0]  ien_q;
   logic [7:0]  dout_q;
   logic [7:0]  oen_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [7:0]  pin_out_q;
   logic [7:0]  pin_oe_q;
   logic        cap0_a_q;
   logic        cap0_b_q;
   logic        cap1_a_q;
   logic        cap1_b_q;
   logic [1:0]  ext_clk_q;

   logic        setup;
   logic        wr_lane;
   logic        mapped;
   logic [7:0]  din;
   logic [7:0]  rd_byte;
   logic [15:0] sel_all;
   logic [7:0]  alt1_val;
   logic [7:0]  alt1_drv;
   logic [7:0]  alt2_val;
   logic [7:0]  alt2_drv;
   logic [7:0]  mux_val;
   logic [7:0]  mux_drv;
   logic [7:0]  alt1_own;

   // The answer is prepared in the setup cycle, so every access has no wait state.
   // A write lands only at the access edge, when the master samples pready high.
   assign setup   = psel & ~penable & ~pready_q;
   assign wr_lane = psel & penable & pready_q & pwrite & pstrb[0];

   assign mapped = addr_hit(paddr, PPFS_ADDR_SEL_LO) | addr_hit(paddr, PPFS_ADDR_SEL_HI)
                 | addr_hit(paddr, PPFS_ADDR_IEN) | addr_hit(paddr, PPFS_ADDR_DIN)
                 | addr_hit(paddr, PPFS_ADDR_DOUT) | addr_hit(paddr, PPFS_ADDR_OEN);

   // A disabled input reads as zero rather than the pin level.
   assign din = pin_in & ien_q;

   always_comb
   begin
      rd_byte = 8'h00;
      if (addr_hit(paddr, PPFS_ADDR_SEL_LO))
      begin
         rd_byte = sel_lo_q;
      end
      else if (addr_hit(paddr, PPFS_ADDR_SEL_HI))
      begin
         rd_byte = sel_hi_q;
      end
      else if (addr_hit(paddr, PPFS_ADDR_IEN))
      begin
         rd_byte = ien_q;
      end
      else if (addr_hit(paddr, PPFS_ADDR_DIN))
      begin
         rd_byte = din;
      end
      else if (addr_hit(paddr, PPFS_ADDR_DOUT))
      begin
         rd_byte = dout_q;
      end
      else if (addr_hit(paddr, PPFS_ADDR_OEN))
      begin
         rd_byte = oen_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready_q <= 1'b0;
      end
      else
      begin
         pready_q <= setup;
      end
   end

   // An unmapped address still answers at once, so a stray access cannot hang the bus.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pslverr_q <= 1'b0;
      end
      else
      begin
         pslverr_q <= setup & ~mapped;
      end
   end

   // Read data holds until the next read, so a slow sampler still sees it.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata_q <= 32'h0000_0000;
      end
      else if (setup && !pwrite)
      begin
         prdata_q <= {24'h00_0000, rd_byte};
      end
   end

   // Reserved codes are kept as written; the pin cell treats them as port use.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sel_lo_q <= PPFS_RST_SEL;
      end
      else if (wr_lane && addr_hit(paddr, PPFS_ADDR_SEL_LO))
      begin
         sel_lo_q <= pwdata[PPFS_REG_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sel_hi_q <= PPFS_RST_SEL;
      end
      else if (wr_lane && addr_hit(paddr, PPFS_ADDR_SEL_HI))
      begin
         sel_hi_q <= pwdata[PPFS_REG_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ien_q <= PPFS_RST_IEN;
      end
      else if (wr_lane && addr_hit(paddr, PPFS_ADDR_IEN))
      begin
         ien_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dout_q <= PPFS_RST_DOUT;
      end
      else if (wr_lane && addr_hit(paddr, PPFS_ADDR_DOUT))
      begin
         dout_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         oen_q <= PPFS_RST_OEN;
      end
      else if (wr_lane && addr_hit(paddr, PPFS_ADDR_OEN))
      begin
         oen_q <= pwdata[7:0];
      end
   end

   // Pin 0 sits in the low field of the low register, pin 7 in the top field of the high one.
   assign sel_all = {sel_hi_q, sel_lo_q};

   // In capture mode the timer pin stops driving and feeds the capture input instead.
   assign alt1_val = {buzzer_out, timer1_compare_out_b, timer1_compare_out_a, 1'b0,
                      timer0_compare_out_b, timer0_compare_out_a, 1'b0,
                      rf_converter_clock_out};
   assign alt1_drv = {1'b1, ~timer1_capture_mode, ~timer1_capture_mode, 1'b0,
                      ~timer0_capture_mode, ~timer0_capture_mode, 1'b0, 1'b1};
   assign alt2_val = {1'b0, ~buzzer_out, 4'h0, 1'b0, regulator_monitor_out};
   assign alt2_drv = PPFS_ALT2_MASK;

   generate
      for (genvar i = 0; i < PPFS_NPINS; i++)
      begin : g_pin
         ppfs_pin_cell u_cell
         (
            .code     (sel_all[PPFS_FIELD_W*i +: PPFS_FIELD_W]),
            .alt1_ok  (PPFS_ALT1_MASK[i]),
            .alt2_ok  (PPFS_ALT2_MASK[i]),
            .port_val (dout_q[i]),
            .port_drv (oen_q[i]),
            .alt1_val (alt1_val[i]),
            .alt1_drv (alt1_drv[i]),
            .alt2_val (alt2_val[i]),
            .alt2_drv (alt2_drv[i]),
            .mux_val  (mux_val[i]),
            .mux_drv  (mux_drv[i]),
            .alt1_own (alt1_own[i])
         );
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_out_q <= 8'h00;
      end
      else
      begin
         pin_out_q <= mux_val;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_oe_q <= 8'h00;
      end
      else
      begin
         pin_oe_q <= mux_drv;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cap0_a_q <= 1'b0;
      end
      else
      begin
         cap0_a_q <= din[2] & alt1_own[2] & timer0_capture_mode;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cap0_b_q <= 1'b0;
      end
      else
      begin
         cap0_b_q <= din[3] & alt1_own[3] & timer0_capture_mode;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cap1_a_q <= 1'b0;
      end
      else
      begin
         cap1_a_q <= din[5] & alt1_own[5] & timer1_capture_mode;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cap1_b_q <= 1'b0;
      end
      else
      begin
         cap1_b_q <= din[6] & alt1_own[6] & timer1_capture_mode;
      end
   end

   // External clocks share the port function, so they only need the input path open;
   // software keeps the output enable low for those pins.
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ext_clk_q <= 2'h0;
      end
      else
      begin
         ext_clk_q[0] <= din[PPFS_PIN_T0_CLK];
         ext_clk_q[1] <= din[PPFS_PIN_T1_CLK];
      end
   end

   assign prdata              = prdata_q;
   assign pready              = pready_q;
   assign pslverr             = pslverr_q;
   assign pin_out             = pin_out_q;
   assign pin_oe              = pin_oe_q;
   assign timer0_capture_in_a = cap0_a_q;
   assign timer0_capture_in_b = cap0_b_q;
   assign timer1_capture_in_a = cap1_a_q;
   assign timer1_capture_in_b = cap1_b_q;
   assign timer0_ext_clock_in = ext_clk_q[0];
   assign timer1_ext_clock_in = ext_clk_q[1];

endmodule : ppfs_top

/* testbench/ppfs_periph_model.sv */
// Purpose: Stand-in for the peripherals that share the port 0 pins.
// Assumes: Peripheral outputs are plain levels synchronous to sys_clk.
// Notes:   Each output toggles at its own rate, so a wrong route shows at the pin.
`timescale 1ns/1ps
module ppfs_periph_model
(
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   output logic      [6:0] sig
);
   logic [6:0] cnt_q;

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         cnt_q <= 7'h00;
      else
         cnt_q <= cnt_q + 7'h01;
   end

   assign sig = cnt_q;
endmodule : ppfs_periph_model

/* testbench/ppfs_top_asserts.sv */
// Purpose: Port-level assertions for the pin function select block.
// Assumes: Select registers are shadowed from APB access-edge writes.
// Notes:   Input enable is not shadowed, so gating checks are one-sided.
`timescale 1ns/1ps
module ppfs_top_asserts
   import ppfs_pkg::*;
(
   input wire logic                   sys_clk,
   input wire logic                   rstn,
   input wire logic [PPFS_ADDR_W-1:0] paddr,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [31:0]            pwdata,
   input wire logic [3:0]             pstrb,
   input wire logic                   pready,
   input wire logic [7:0]             pin_in,
   input wire logic [7:0]             pin_out,
   input wire logic [7:0]             pin_oe,
   input wire logic                   timer0_compare_out_a,
   input wire logic                   timer0_compare_out_b,
   input wire logic                   timer1_compare_out_a,
   input wire logic                   timer0_capture_mode,
   input wire logic                   timer1_capture_mode,
   input wire logic                   buzzer_out,
   input wire logic                   rf_converter_clock_out,
   input wire logic                   regulator_monitor_out,
   input wire logic                   timer0_capture_in_a,
   input wire logic                   timer0_ext_clock_in,
   input wire logic                   timer1_ext_clock_in
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   logic [7:0] lo_q;
   logic [7:0] hi_q;
   wire logic  wr = psel && penable && pready && pwrite && pstrb[0];

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lo_q <= PPFS_RST_SEL;
         hi_q <= PPFS_RST_SEL;
      end
      else if (wr && paddr == PPFS_ADDR_SEL_LO)
         lo_q <= pwdata[7:0];
      else if (wr && paddr == PPFS_ADDR_SEL_HI)
         hi_q <= pwdata[7:0];
   end

   rf_clk_a: assert property (
      lo_q[1:0] == 2'h1 |=> pin_oe[0] && pin_out[0] == $past(rf_converter_clock_out))
      else $error("pin 0 does not carry the rf clock");
   reg_mon_a: assert property (
      lo_q[1:0] == 2'h2 |=> pin_out[0] == $past(regulator_monitor_out))
      else $error("pin 0 does not carry the monitor");
   t0_out_b_a: assert property (
      lo_q[7:6] == 2'h1 && !timer0_capture_mode |=> pin_out[3] == $past(timer0_compare_out_b))
      else $error("pin 3 does not carry timer0 b");
   t0_out_a_a: assert property (
      lo_q[5:4] == 2'h1 && !timer0_capture_mode |=> pin_out[2] == $past(timer0_compare_out_a))
      else $error("pin 2 does not carry timer0 a");
   t1_out_a_a: assert property (
      hi_q[3:2] == 2'h1 && !timer1_capture_mode
         |=> pin_oe[5] && pin_out[5] == $past(timer1_compare_out_a))
      else $error("pin 5 does not carry timer1 a");
   cap_pin_oe_a: assert property (
      lo_q[7:6] == 2'h1 && timer0_capture_mode |=> !pin_oe[3])
      else $error("pin 3 drives in capture mode");
   buzzer_a: assert property (
      hi_q[7:6] == 2'h1 |=> pin_out[7] == $past(buzzer_out))
      else $error("pin 7 does not carry the buzzer");
   buzzer_inv_a: assert property (
      hi_q[5:4] == 2'h2 |=> pin_out[6] != $past(buzzer_out))
      else $error("pin 6 does not carry the inverted buzzer");
   cap0_a_a: assert property (
      timer0_capture_in_a |-> $past(pin_in[2] && timer0_capture_mode && lo_q[5:4] == 2'h1))
      else $error("timer0 capture a without cause");
   ext_clk0_a: assert property (
      timer0_ext_clock_in |-> $past(pin_in[1]))
      else $error("timer0 clock high with pin 1 low");
   ext_clk1_a: assert property (
      timer1_ext_clock_in |-> $past(pin_in[4]))
      else $error("timer1 clock high with pin 4 low");
endmodule : ppfs_top_asserts

bind ppfs_top ppfs_top_asserts u_chk (.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite,
   .pwdata, .pstrb, .pready, .pin_in, .pin_out, .pin_oe, .timer0_compare_out_a,
   .timer0_compare_out_b, .timer1_compare_out_a, .timer0_capture_mode, .timer1_capture_mode,
   .buzzer_out, .rf_converter_clock_out, .regulator_monitor_out, .timer0_capture_in_a,
   .timer0_ext_clock_in, .timer1_ext_clock_in);

/* testbench/tb.sv */
// Purpose: Self-checking bench for the port 0 pin function select block.
// Assumes: APB master leaves one idle cycle between transfers.
// Notes:   Pin wires take the design's drive where enabled, else the bench level.
`timescale 1ns/1ps
module tb
   import ppfs_pkg::*;
;
   logic                   sys_clk = 1'b0;
   logic                   rstn    = 1'b0;
   logic [PPFS_ADDR_W-1:0] paddr   = '0;
   logic                   psel    = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite  = 1'b0;
   logic [31:0]            pwdata  = '0;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [7:0]             ext_q   = 8'h00;
   logic [7:0]             pin_in;
   logic [7:0]             pin_out;
   logic [7:0]             pin_oe;
   logic                   t0cap   = 1'b0;
   logic                   t1cap   = 1'b0;
   logic [6:0]             per;
   logic [5:0]             cap;
   logic [31:0]            rd;
   logic                   rerr;
   logic [7:0]             pat [3] = '{8'h1B, 8'hE4, 8'h00};
   logic [7:0]             v;
   int                     n_fail      = 0;
   int                     checks_done = 0;

   always #5 sys_clk = ~sys_clk;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_q);

   ppfs_periph_model u_per (.sys_clk, .rstn, .sig(per));
   ppfs_top uut (.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF),
      .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
      .timer0_compare_out_a(per[3]), .timer0_compare_out_b(per[4]),
      .timer1_compare_out_a(per[5]), .timer1_compare_out_b(per[6]),
      .timer0_capture_mode(t0cap), .timer1_capture_mode(t1cap), .buzzer_out(per[2]),
      .rf_converter_clock_out(per[1]), .regulator_monitor_out(per[0]),
      .timer0_capture_in_a(cap[0]), .timer0_capture_in_b(cap[1]), .timer1_capture_in_a(cap[2]),
      .timer1_capture_in_b(cap[3]), .timer0_ext_clock_in(cap[4]), .timer1_ext_clock_in(cap[5]));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // A hung slave counts as a mismatch and ends the run at once.
   task automatic apb(input logic [PPFS_ADDR_W-1:0] a, input logic w, input logic [7:0] d);
      int i;
      @(posedge sys_clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, d};
      psel <= 1'b1;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 8; i++)
      begin
         @(posedge sys_clk);
         if (pready === 1'b1)
            break;
      end
      if (i == 8)
      begin
         n_fail++;
         end_sim();
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rc(input logic [PPFS_ADDR_W-1:0] a, input logic [7:0] exp);
      apb(a, 1'b0, 8'h00);
      chk(rd, {24'h0, exp});
   endtask : rc

   initial
   begin
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      rc(PPFS_ADDR_SEL_LO, 8'h00);
      rc(PPFS_ADDR_SEL_HI, 8'h00);
      rc(PPFS_ADDR_IEN, 8'hFF);
      foreach (pat[i])
      begin
         apb(PPFS_ADDR_SEL_LO, 1'b1, pat[i]);
         apb(PPFS_ADDR_SEL_HI, 1'b1, ~pat[i]);
         rc(PPFS_ADDR_SEL_LO, pat[i]);
         rc(PPFS_ADDR_SEL_HI, ~pat[i]);
      end
      apb(20'h00010, 1'b0, 8'h00);
      chk(rd, 32'h0000_0000);
      chk({31'h0000_0000, rerr}, 32'h0000_0001);
      $display("register test done");
      apb(PPFS_ADDR_SEL_LO, 1'b1, 8'hFF);
      apb(PPFS_ADDR_DOUT, 1'b1, 8'hA5);
      apb(PPFS_ADDR_OEN, 1'b1, 8'hF0);
      repeat (3) @(posedge sys_clk);
      chk({pin_oe, pin_out}, 16'hF0A5);
      $display("reserved code test done");
      apb(PPFS_ADDR_OEN, 1'b1, 8'h00);
      apb(PPFS_ADDR_SEL_LO, 1'b1, 8'h42);
      apb(PPFS_ADDR_SEL_HI, 1'b1, 8'h64);
      repeat (20) @(posedge sys_clk);
      chk(pin_oe, 8'hE9);
      apb(PPFS_ADDR_SEL_LO, 1'b1, 8'h41);
      repeat (20) @(posedge sys_clk);
      $display("function route test done");
      apb(PPFS_ADDR_SEL_HI, 1'b1, 8'h14);
      apb(PPFS_ADDR_SEL_LO, 1'b1, 8'h50);
      t0cap <= 1'b1;
      t1cap <= 1'b1;
      foreach (pat[i])
      begin
         v = pat[i] ^ 8'hBE;
         ext_q <= v;
         repeat (3) @(posedge sys_clk);
         chk(cap, {v[4], v[1], v[6], v[5], v[3], v[2]});
         rc(PPFS_ADDR_DIN, v);
      end
      apb(PPFS_ADDR_IEN, 1'b1, 8'h00);
      repeat (3) @(posedge sys_clk);
      chk(cap, 6'h00);
      rc(PPFS_ADDR_DIN, 8'h00);
      $display("input enable test done");
      end_sim();
   end
endmodule : tb
